// file: bench/blsu_mem_model.sv
/*
  Memory partner: byte store, reads answered one cycle later.
  Assumes the load/store unit top drives all its request ports; the bench drives clock.
*/
`timescale 1ns/1ns
module blsu_mem_model
  import blsu_pkg::*;
(
  input  wire logic                     clock,
  input  wire blsu_pkg::blsu_mem_req_t  req0,
  input  wire blsu_pkg::blsu_mem_req_t  req1,
  input  wire blsu_pkg::blsu_fetch_req_t fet,
  input  wire blsu_pkg::blsu_mem_req_t  dma,
  output logic [63:0]                   rd0,
  output logic [63:0]                   rd1,
  output logic [127:0]                  frd
);
  logic [7:0] mem [int];
  // =====
  // Unwritten bytes show a fixed address pattern
  function automatic logic [7:0] rb(input int a);
    return mem.exists(a) ? mem[a] : 8'(a) ^ 8'h5a;
  endfunction : rb
  // Lowest address lands in the top lane
  function automatic logic [63:0] rdw(input logic [31:0] a);
    logic [63:0] d;
    for (int k = 0; k < 8; k++)
      d[63-8*k -: 8] = rb(int'({a[31:3], 3'h0}) + k);
    return d;
  endfunction : rdw
  task automatic wr(input blsu_mem_req_t r);
    for (int k = 0; k < 8; k++)
      if (r.valid && r.write && r.be[7-k])
        mem[int'({r.addr[31:3], 3'h0}) + k] = r.wdata[63-8*k -: 8];
  endtask : wr
  initial
  begin
    rd0 = '0;
    rd1 = '0;
    frd = '0;
  end
  // =====
  // Idle read lines flip so stale data never looks valid
  always @(posedge clock)
  begin
    rd0 <= (req0.valid && !req0.write) ? rdw(req0.addr) : ~rd0;
    rd1 <= (req1.valid && !req1.write) ? rdw(req1.addr) : ~rd1;
    frd <= fet.valid ? {rdw(fet.addr), rdw(fet.addr | 32'h8)} : ~frd;
    wr(req0);
    wr(req1);
    wr(dma);
  end
endmodule : blsu_mem_model

// file: bench/blsu_top_tb_top.sv
/*
  Bench of the load/store unit: staged stimulus, queued expectations.
  Assumes blsu_mem_model stands in for the unified memory.
*/
`timescale 1ns/1ns
module blsu_top_tb_top;
  import blsu_pkg::*;
  logic            clock, resetn, fetchReady_r, fetchDataValid_r, aluArm, dmaOn;
  logic [3:0]      aluValid, aluGo_r, aluCur, aluPrev;
  blsu_agu_op_t    agu0, agu1, op0, op1;
  blsu_ptr_wr_t    ptrWr, pw;
  blsu_fetch_req_t fetchReq, fr, fetchMem_r;
  blsu_mem_req_t   dmaReq, dr, memReq0_r, memReq1_r, dmaMem_r;
  logic [63:0]     memRdata0, memRdata1, ldData0_r, ldData1_r;
  logic [127:0]    fetchRdata, fetchData_r;
  logic [1:0]      ldValid_r, alignErr_r;
  logic [127:0]    expQ [8][$];
  logic [7:0]      mir [int];
  logic [31:0]     ptrM [8];
  logic [31:0]     seed, a;
  logic [1:0]      sz;
  int              fails, cmp_count;

  blsu_top i_dut (.clock(clock), .resetn(resetn), .aluValid(aluValid),
    .agu0(agu0), .agu1(agu1), .ptrWr(ptrWr), .fetchReq(fetchReq),
    .dmaReq(dmaReq), .memRdata0(memRdata0), .memRdata1(memRdata1),
    .fetchRdata(fetchRdata), .memReq0_r(memReq0_r), .memReq1_r(memReq1_r),
    .fetchMem_r(fetchMem_r), .dmaMem_r(dmaMem_r),
    .fetchReady_r(fetchReady_r), .fetchData_r(fetchData_r),
    .fetchDataValid_r(fetchDataValid_r), .ldValid_r(ldValid_r),
    .ldData0_r(ldData0_r), .ldData1_r(ldData1_r),
    .alignErr_r(alignErr_r), .aluGo_r(aluGo_r));
  blsu_mem_model i_mem (.clock(clock), .req0(memReq0_r), .req1(memReq1_r),
    .fet(fetchMem_r), .dma(dmaMem_r), .rd0(memRdata0), .rd1(memRdata1),
    .frd(fetchRdata));

  // =====
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] mb(input int x);
    return mir.exists(x) ? mir[x] : 8'(x) ^ 8'h5a;
  endfunction : mb
  function automatic logic [127:0] rq(input blsu_mem_req_t r);
    logic [63:0] m;
    for (int k = 0; k < 8; k++)
      m[8*k +: 8] = {8{r.be[k] & r.write}};
    return 128'({r.write, r.addr, r.be, r.wdata & m});
  endfunction : rq
  function automatic logic busy();
    for (int k = 0; k < 8; k++)
      if (expQ[k].size() != 0)
        return 1'b1;
    return 1'b0;
  endfunction : busy
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pop(input int k, input logic [127:0] got);
    if (expQ[k].size() == 0)
      chk(got, ~got);
    else
      chk(got, expQ[k].pop_front());
  endtask : pop
  task automatic tally_and_finish();
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // =====
  // One edge: staged requests go out together, then staging clears
  task automatic step();
    logic [127:0] t;
    @(posedge clock);
    t = {rnd(), rnd(), rnd(), rnd()};
    dr = t[105:0];
    dr.addr[31] = 1'b1;
    dr.valid = dr.valid & dmaOn;
    if (dr.valid)
      expQ[7].push_back(128'(dr));
    aluPrev = aluCur;
    aluCur = (op0.valid && op1.valid) ? 4'hf : 4'(rnd());
    agu0 <= op0;
    agu1 <= op1;
    ptrWr <= pw;
    fetchReq <= fr;
    dmaReq <= dr;
    aluValid <= aluCur;
    op0 = '0;
    op1 = '0;
    pw = '0;
    fr = '0;
    aluArm = 1'b1;
    #1;
  endtask : step
  task automatic setp(input logic [2:0] i, input logic [31:0] v);
    pw = '{1'b1, i, v};
    ptrM[i] = v;
  endtask : setp
  // Stage one address op and note its request, load data or refusal
  task automatic op(input int ch, input logic w, input logic [1:0] s,
                    input logic pi, input logic [2:0] p, input logic [63:0] v);
    logic [31:0] x;
    logic [7:0]  be;
    logic [63:0] wd, ld;
    int          n;
    x = ptrM[p];
    n = 1 << s;
    be = '0;
    wd = '0;
    ld = '0;
    if (ch == 0) op0 = '{1'b1, w, s, pi, p, v};
    else op1 = '{1'b1, w, s, pi, p, v};
    if ((x & 32'(n - 1)) != 0)
    begin
      expQ[4].push_back(128'(ch));
      return;
    end
    for (int j = 0; j < n; j++)
    begin
      be[7 - x[2:0] - j] = 1'b1;
      wd[63 - 8*(x[2:0] + j) -: 8] = v[8*(n-1-j) +: 8];
      ld = {ld[55:0], mb(int'(x) + j)};
      if (w) mir[int'(x) + j] = v[8*(n-1-j) +: 8];
    end
    expQ[ch].push_back(128'({w, x, be, w ? wd : 64'h0}));
    if (!w) expQ[ch + 2].push_back(128'(ld));
    if (pi) ptrM[p] = x + 32'(n);
  endtask : op
  task automatic fetch(input logic [31:0] x);
    logic [127:0] d;
    fr = '{1'b1, x};
    for (int k = 0; k < 16; k++)
      d = {d[119:0], mb(int'(x & 32'hfffffff0) + k)};
    expQ[5].push_back(128'(x & 32'hfffffff0));
    expQ[6].push_back(d);
  endtask : fetch

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // =====
  // Every result except aluGo_r and fetchReady_r is matched against the oldest note of its kind; aluGo_r is checked against aluPrev
  always @(negedge clock)
  begin
    if (memReq0_r.valid === 1'b1) pop(0, rq(memReq0_r));
    if (memReq1_r.valid === 1'b1) pop(1, rq(memReq1_r));
    if (ldValid_r[0] === 1'b1) pop(2, 128'(ldData0_r));
    if (ldValid_r[1] === 1'b1) pop(3, 128'(ldData1_r));
    if (alignErr_r[0] === 1'b1) pop(4, 128'h0);
    if (alignErr_r[1] === 1'b1) pop(4, 128'h1);
    if (fetchMem_r.valid === 1'b1) pop(5, 128'(fetchMem_r.addr));
    if (fetchDataValid_r === 1'b1) pop(6, fetchData_r);
    if (dmaMem_r.valid === 1'b1) pop(7, 128'(dmaMem_r));
    if (aluArm) chk(128'(aluGo_r), 128'(aluPrev));
  end

  initial
  begin
    {seed, fails, cmp_count, aluArm, aluCur, aluPrev} = {32'd57933, 73'h0};
    {resetn, aluValid, agu0, agu1, ptrWr, fetchReq, dmaReq} = '0;
    {op0, op1, pw, fr, dmaOn} = '0;
    for (int i = 0; i < 8; i++) ptrM[i] = '0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    dmaOn = 1'b1;
    step();
    chk(128'(fetchReady_r), 128'h1);
    // Pointers come out of reset at zero; bytes are consecutive
    op(1, 1'b0, 2'h0, 1'b1, 3'h2, 64'h0);
    step();
    op(1, 1'b0, 2'h0, 1'b1, 3'h2, 64'h0);
    setp(0, 32'h1234);
    step();
    op(0, 1'b1, 2'h2, 1'b1, 3'h0, 64'hcafef00d);
    setp(1, 32'h1234);
    step();
    op(1, 1'b0, 2'h0, 1'b1, 3'h1, 64'h0);
    step();
    op(0, 1'b0, 2'h1, 1'b1, 3'h1, 64'h0);
    op(1, 1'b0, 2'h2, 1'b0, 3'h0, 64'h0);
    step();
    op(1, 1'b0, 2'h3, 1'b0, 3'h1, 64'h0);
    op(0, 1'b0, 2'h0, 1'b1, 3'h1, 64'h0);
    step();
    op(1, 1'b0, 2'h1, 1'b1, 3'h1, 64'h0);
    step();
    op(1, 1'b0, 2'h3, 1'b0, 3'h1, 64'h0);
    step();
    // Fetch alone, then a fetch held back by a data access
    fetch(32'h3004);
    setp(5, 32'h3100);
    step();
    step();
    chk(128'(fetchMem_r.valid), 128'h1);
    fetch(32'h300c);
    op(1, 1'b0, 2'h1, 1'b0, 3'h5, 64'h0);
    step();
    step();
    chk(128'({fetchMem_r.valid, fetchReady_r}), 128'h0);
    step();
    chk(128'(fetchMem_r.valid), 128'h1);
    // Random aligned store and read-back of every size
    for (int i = 0; i < 24; i++)
    begin
      sz = 2'(rnd());
      a = 32'h2000 | (rnd() & 32'hff) & ~((32'h1 << sz) - 1);
      setp(3, a);
      step();
      setp(4, a);
      op(0, 1'b1, sz, 1'b1, 3'h3, {rnd(), rnd()});
      step();
      op(1, 1'b0, sz, 1'(rnd()), 3'h4, 64'h0);
      op(0, 1'b0, sz, 1'b0, 3'h3, 64'h0);
      step();
    end
    dmaOn = 1'b0;
    for (int i = 0; i < 20 && busy(); i++) step();
    chk(128'(busy()), 128'h0);
    tally_and_finish();
  end
endmodule : blsu_top_tb_top

// file: hw/blsu_agen.sv
/*
  One address arithmetic channel: byte address, alignment check,
  post-increment value and big-endian lane placement.
  Assumes the pointer value is read combinationally by the caller.
*/
`timescale 1ns/1ns
module blsu_agen
  import blsu_pkg::*;
(
  input  wire blsu_pkg::blsu_agu_op_t  op,
  input  wire logic [31:0]             ptrVal,
  output blsu_pkg::blsu_mem_req_t      req,
  output logic                         alignErr,
  output logic                         ptrUpd,
  output logic [31:0]                  ptrNxt
);
  logic [2:0] off;

  // ============================================================
  // Address and checks; pointer is already a byte address
  assign off      = ptrVal[2:0];
  assign alignErr = op.valid && misaligned(op.size, off);
  assign ptrUpd   = op.valid && op.postInc && !alignErr;
  // Step by operand size: 1 for byte, 2 for word
  assign ptrNxt   = ptrVal + 32'(sizeBytes(op.size));

  // Memory request, write data placed MSB first
  always_comb
  begin
    req.valid = op.valid && !alignErr;
    req.write = op.write;
    req.addr  = ptrVal;
    req.wdata = placeStore(op.wdata, op.size, off);
    req.be    = laneMask(op.size, off);
  end
endmodule : blsu_agen

// file: hw/blsu_top.sv
/*
  Load/store unit of a 16-bit core with byte-addressed unified memory:
  two address channels, pointer file, load return, program fetch
  arbitration against data subgroups and a separate DMA port.
  Assumes memory answers every read exactly one cycle after the request
  and that requesters only fetch while fetchReady is high.
*/
`timescale 1ns/1ns
module blsu_top
  import blsu_pkg::*;
(
  input  wire logic                     clock,
  input  wire logic                     resetn,
  input  wire logic [3:0]               aluValid,
  input  wire blsu_pkg::blsu_agu_op_t   agu0,
  input  wire blsu_pkg::blsu_agu_op_t   agu1,
  input  wire blsu_pkg::blsu_ptr_wr_t   ptrWr,
  input  wire blsu_pkg::blsu_fetch_req_t fetchReq,
  input  wire blsu_pkg::blsu_mem_req_t  dmaReq,
  input  wire logic [63:0]              memRdata0,
  input  wire logic [63:0]              memRdata1,
  input  wire logic [127:0]             fetchRdata,
  output blsu_pkg::blsu_mem_req_t       memReq0_r,
  output blsu_pkg::blsu_mem_req_t       memReq1_r,
  output blsu_pkg::blsu_fetch_req_t     fetchMem_r,
  output blsu_pkg::blsu_mem_req_t       dmaMem_r,
  output logic                          fetchReady_r,
  output logic [127:0]                  fetchData_r,
  output logic                          fetchDataValid_r,
  output logic [1:0]                    ldValid_r,
  output logic [63:0]                   ldData0_r,
  output logic [63:0]                   ldData1_r,
  output logic [1:0]                    alignErr_r,
  output logic [3:0]                    aluGo_r
);
  // ============================================================
  // Pointer file and channels
  logic [31:0]   ptr_r [`BLSU_NPTR];
  blsu_mem_req_t req0, req1;
  logic          err0, err1, upd0, upd1;
  logic [31:0]   nxt0, nxt1;
  logic [1:0]    ldSz_r [2];
  logic [1:0]    szQ_r [2];
  logic [2:0]    ldOff_r [2];
  logic [1:0]    ldPend_r;
  blsu_fstate_t  fstate_r;
  logic [31:0]   fHeld_r;
  logic          fPend_r;
  logic          conflict;

  blsu_agen u_agen0 (
    .op       (agu0),
    .ptrVal   (ptr_r[agu0.ptr]),
    .req      (req0),
    .alignErr (err0),
    .ptrUpd   (upd0),
    .ptrNxt   (nxt0)
  );

  blsu_agen u_agen1 (
    .op       (agu1),
    .ptrVal   (ptr_r[agu1.ptr]),
    .req      (req1),
    .alignErr (err1),
    .ptrUpd   (upd1),
    .ptrNxt   (nxt1)
  );

  // Pointer update; channel 0 wins a clash, external load wins both
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `BLSU_NPTR; i++)
        ptr_r[i] <= `BLSU_PTR_RST;
    end
    else
    begin
      if (upd1)
        ptr_r[agu1.ptr] <= nxt1;
      if (upd0)
        ptr_r[agu0.ptr] <= nxt0;
      if (ptrWr.valid)
        ptr_r[ptrWr.idx] <= ptrWr.data;
    end
  end

  // ============================================================
  // Data requests; both channels and ALU slots issue in one cycle
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      memReq0_r  <= '0;
      memReq1_r  <= '0;
      alignErr_r <= 2'h0;
      aluGo_r    <= 4'h0;
    end
    else
    begin
      memReq0_r  <= req0;
      memReq1_r  <= req1;
      alignErr_r <= {err1, err0};
      aluGo_r    <= aluValid;
    end
  end

  // Load return, right justified; memory answers one cycle later
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ldPend_r  <= 2'h0;
      ldValid_r <= 2'h0;
      ldData0_r <= 64'h0;
      ldData1_r <= 64'h0;
      ldSz_r    <= '{default: 2'h0};
      szQ_r     <= '{default: 2'h0};
      ldOff_r   <= '{default: 3'h0};
    end
    else
    begin
      // Pending tracks the issued request, so data is taken in the cycle
      // the memory really drives it, not the cycle before
      ldPend_r   <= {memReq1_r.valid && !memReq1_r.write,
                     memReq0_r.valid && !memReq0_r.write};
      szQ_r[0]   <= agu0.size;
      szQ_r[1]   <= agu1.size;
      ldSz_r[0]  <= szQ_r[0];
      ldSz_r[1]  <= szQ_r[1];
      ldOff_r[0] <= memReq0_r.addr[2:0];
      ldOff_r[1] <= memReq1_r.addr[2:0];
      ldValid_r  <= ldPend_r;
      if (ldPend_r[0])
        ldData0_r <= pickLoad(memRdata0, ldSz_r[0], ldOff_r[0]);
      if (ldPend_r[1])
        ldData1_r <= pickLoad(memRdata1, ldSz_r[1], ldOff_r[1]);
    end
  end

  // ============================================================
  // Fetch arbitration: data wins a shared subgroup, fetch waits one
  // cycle; holding only one cycle keeps fetch from starving.
  assign conflict = fetchReq.valid && fstate_r == FS_IDLE &&
    ((req0.valid && req0.addr[`BLSU_SUBGRP_HI:`BLSU_SUBGRP_LO] ==
      fetchReq.addr[`BLSU_SUBGRP_HI:`BLSU_SUBGRP_LO]) ||
     (req1.valid && req1.addr[`BLSU_SUBGRP_HI:`BLSU_SUBGRP_LO] ==
      fetchReq.addr[`BLSU_SUBGRP_HI:`BLSU_SUBGRP_LO]));

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      fstate_r     <= FS_IDLE;
      fHeld_r      <= 32'h0;
      fetchMem_r   <= '0;
      fetchReady_r <= 1'b0;
    end
    else
    begin
      fetchReady_r <= !conflict;
      case (fstate_r)
        FS_IDLE:
        begin
          fHeld_r          <= fetchReq.addr & `BLSU_FETCH_ALIGN;
          fetchMem_r.addr  <= fetchReq.addr & `BLSU_FETCH_ALIGN;
          fetchMem_r.valid <= fetchReq.valid && !conflict;
          if (conflict)
            fstate_r <= FS_HELD;
        end
        FS_HELD:
        begin
          fetchMem_r.addr  <= fHeld_r;
          fetchMem_r.valid <= 1'b1;
          fstate_r         <= FS_IDLE;
        end
        default:
          fstate_r <= FS_IDLE;
      endcase
    end
  end

  // Fetch set return, full 128-bit width
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      fPend_r          <= 1'b0;
      fetchDataValid_r <= 1'b0;
      fetchData_r      <= 128'h0;
    end
    else
    begin
      fPend_r          <= fetchMem_r.valid;
      fetchDataValid_r <= fPend_r;
      if (fPend_r)
        fetchData_r <= fetchRdata;
    end
  end

  // DMA keeps its own port into the unified memory
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      dmaMem_r <= '0;
    else
      dmaMem_r <= dmaReq;
  end

  // ============================================================
  // Checks
  sequence s_fetchHeld;
    !fetchMem_r.valid ##1 fetchMem_r.valid;
  endsequence

  a_bigend_store: assert property (@(posedge clock) disable iff (!resetn)
    agu0.valid && agu0.write && agu0.size == `BLSU_SZ_LONG &&
    ptr_r[agu0.ptr][2:0] == 3'h0
    |=> memReq0_r.be == 8'hf0 &&
        memReq0_r.wdata[63:56] == $past(agu0.wdata[31:24]))
    else $error("long store not most significant byte first");

  a_byte_address: assert property (@(posedge clock) disable iff (!resetn)
    agu0.valid && !err0 |=> memReq0_r.addr == $past(ptr_r[agu0.ptr]))
    else $error("issued address differs from pointer");

  a_inc_word: assert property (@(posedge clock) disable iff (!resetn)
    agu1.valid && agu1.postInc && agu1.size == `BLSU_SZ_WORD && !err1 &&
    !(upd0 && agu0.ptr == agu1.ptr) &&
    !(ptrWr.valid && ptrWr.idx == agu1.ptr)
    |=> ptr_r[$past(agu1.ptr)] == $past(ptr_r[agu1.ptr]) + 32'h2)
    else $error("word post-increment not two");

  a_inc_byte: assert property (@(posedge clock) disable iff (!resetn)
    agu0.valid && agu0.postInc && agu0.size == `BLSU_SZ_BYTE &&
    !(ptrWr.valid && ptrWr.idx == agu0.ptr)
    |=> ptr_r[$past(agu0.ptr)] == $past(ptr_r[agu0.ptr]) + 32'h1)
    else $error("byte post-increment not one");

  a_align_err: assert property (@(posedge clock) disable iff (!resetn)
    agu0.valid && agu0.size == `BLSU_SZ_WORD && ptr_r[agu0.ptr][0]
    |=> alignErr_r[0] && !memReq0_r.valid)
    else $error("odd word access not refused");

  a_load_return: assert property (@(posedge clock) disable iff (!resetn)
    memReq0_r.valid && !memReq0_r.write && memReq0_r.be == 8'hff
    |=> ##1 ldValid_r[0] && ldData0_r == $past(memRdata0))
    else $error("quad load not returned whole");

  a_alu_issue: assert property (@(posedge clock) disable iff (!resetn)
    aluValid == 4'hf && req0.valid && req1.valid
    |=> aluGo_r == 4'hf && memReq0_r.valid && memReq1_r.valid)
    else $error("four ALU ops and two accesses not issued together");

  a_fetch_defer: assert property (@(posedge clock) disable iff (!resetn)
    conflict |=> s_fetchHeld ##0 fetchMem_r.addr == $past(fHeld_r))
    else $error("conflicting fetch not delayed by one cycle");

  a_fetch_set: assert property (@(posedge clock) disable iff (!resetn)
    fetchMem_r.valid |=> ##1 fetchDataValid_r &&
      fetchData_r == $past(fetchRdata))
    else $error("fetch set not returned");

  a_dma_port: assert property (@(posedge clock) disable iff (!resetn)
    dmaReq.valid |=> dmaMem_r.valid && dmaMem_r.addr == $past(dmaReq.addr))
    else $error("DMA request not on its own port");
endmodule : blsu_top

// file: pkg/blsu_map.svh
/*
  Constants of the byte-addressed load/store unit: widths, size codes,
  alignment masks, subgroup field and reset values.
  Assumes inclusion by bare name from the package; the design files use its macros without including it.
*/
// Contract
// - Store multi-byte values most significant byte first
// - Every address value selects exactly one byte
// - Post-increment of 2-byte access adds two
// - Post-increment of byte access adds one
// - Address buses toward memory are 32 bits
// - Data buses move up to 64 bits
// - Program fetch bus is 128 bits wide
// - Four ALU ops plus two address calculations
// - One unified program/data memory, several ports
// - DMA reaches memory through its own port
// - Same-subgroup fetch and data access arbitrated
`ifndef BLSU_MAP_SVH
`define BLSU_MAP_SVH
// ============================================================
// Bus widths, pointer and ALU counts
`define BLSU_ADDR_W   32
`define BLSU_DATA_W   64
`define BLSU_FETCH_W  128
`define BLSU_LANES    8
`define BLSU_NPTR     8
`define BLSU_NALU     4
// ============================================================
// Operand size codes
`define BLSU_SZ_BYTE  2'h0
`define BLSU_SZ_WORD  2'h1
`define BLSU_SZ_LONG  2'h2
`define BLSU_SZ_QUAD  2'h3
// ============================================================
// Alignment, subgroup field, reset values
`define BLSU_FETCH_ALIGN 32'hfffffff0
`define BLSU_SUBGRP_LO   12
`define BLSU_SUBGRP_HI   15
`define BLSU_PTR_RST     32'h0
`endif

// file: pkg/blsu_pkg.sv
/*
  Types and shared functions of the load/store unit.
  Assumes blsu_map.svh is on the include path.
*/
`include "blsu_map.svh"
package blsu_pkg;
  // ============================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  size;
    logic        postInc;
    logic [2:0]  ptr;
    logic [63:0] wdata;
  } blsu_agu_op_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic [7:0]  be;
  } blsu_mem_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } blsu_fetch_req_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  idx;
    logic [31:0] data;
  } blsu_ptr_wr_t;

  typedef enum logic {FS_IDLE, FS_HELD} blsu_fstate_t;

  // ============================================================
  // Size and lane helpers
  function automatic int sizeBytes(input logic [1:0] sz);
    return 1 << sz;
  endfunction : sizeBytes

  // Natural alignment: low size bits must be zero
  function automatic logic misaligned(input logic [1:0] sz,
                                      input logic [2:0] off);
    logic [2:0] m;
    m = 3'((1 << sz) - 1);
    return (off & m) != 3'h0;
  endfunction : misaligned

  // Big-endian lanes: lowest address is the top byte lane
  function automatic logic [7:0] laneMask(input logic [1:0] sz,
                                          input logic [2:0] off);
    logic [7:0] m;
    m = 8'(8'hff << (8 - sizeBytes(sz)));
    return 8'(m >> off);
  endfunction : laneMask

  function automatic logic [63:0] placeStore(input logic [63:0] d,
                                             input logic [1:0]  sz,
                                             input logic [2:0]  off);
    logic [63:0] t;
    t = 64'(d << (64 - 8 * sizeBytes(sz)));
    return 64'(t >> (8 * off));
  endfunction : placeStore

  function automatic logic [63:0] pickLoad(input logic [63:0] d,
                                           input logic [1:0]  sz,
                                           input logic [2:0]  off);
    logic [63:0] t;
    t = 64'(d << (8 * off));
    return 64'(t >> (64 - 8 * sizeBytes(sz)));
  endfunction : pickLoad
endpackage : blsu_pkg
